// [include/afp_pkg.sv]
// Package for the amplifier fault protection sequencer: constants and carriers.
// Assumes a 10 MHz clock; comparator flags arrive asynchronous and are synchronised.
package afp_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RAMP_MS         = 20;
    localparam int unsigned RAMP_CYC        = RAMP_MS * (CLK_HZ / 1000);
    localparam int unsigned CLIP_PULSE_NS   = 500;
    localparam int unsigned CLIP_PULSE_CYC  = (CLIP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned INJECT_EVERY    = 4;
    localparam int unsigned OLP_COUNT_MAX   = 15;
    localparam int unsigned FRAME_DIV       = 25;
    localparam int unsigned SHORT_STEP_CYC  = 100;

    // Comparator flags: 4-bit fields per half-bridge (index 0..3 are A..D), 2-bit fields per channel, the rest global.
    typedef struct packed {
        logic [3:0] over_current;
        logic [3:0] boot_uv;
        logic [1:0] imbalance;
        logic [1:0] clipping;
        logic       short_gnd;
        logic       short_rail;
        logic       undervoltage_guard;
        logic       overvoltage_guard;
        logic       thermal_warning;
        logic       thermal_shutdown;
    } afp_flags_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_CHECK_GND,
        ST_CHECK_RAIL,
        ST_RAMP_UP,
        ST_RUN,
        ST_RAMP_DOWN
    } afp_state_t;

endpackage

// [test/afp_mcu_model.sv]
// Behavioural system controller: reset pin, open-drain mute, pulled-up status pins.
// Assumes the bench states when it wants reset and mute.
`timescale 1ns/1ps
module afp_mcu_model #(
    parameter int unsigned HOLD_CYC = 40000
) (
    input  wire logic i_clk,
    input  wire logic i_reset_req,
    input  wire logic i_mute_req,
    input  wire logic i_fault_oe,
    input  wire logic i_thermal_clip_oe,
    input  wire logic i_mute_oe,
    input  wire logic i_mute_charge,
    output logic      o_reset_pin_n,
    output logic      o_mute_node,
    output logic      o_fault_n,
    output logic      o_clip_n
);
    int unsigned since_fall = HOLD_CYC;
    logic        fault_q    = 1'b1;
    assign o_fault_n = !i_fault_oe;
    assign o_clip_n  = !i_thermal_clip_oe;
    always @(posedge i_clk) begin
        fault_q    <= o_fault_n;
        since_fall <= (fault_q && !o_fault_n) ? 0 : since_fall + 1;
        if (!i_reset_req) o_reset_pin_n <= 1'b0;
        else if (since_fall >= HOLD_CYC) o_reset_pin_n <= 1'b1;
        // Open drain: the node keeps its charge unless someone moves it.
        if (i_mute_req || i_mute_oe) o_mute_node <= 1'b0;
        else if (i_mute_charge) o_mute_node <= 1'b1;
    end
endmodule // afp_mcu_model

// [test/afp_seq_assertions.sv]
// Checker for afp_seq, seeing only its ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module afp_seq_assertions #(
    parameter int unsigned RAMP_CYCLES = 50,
    parameter int unsigned OLP_MAX     = 3
) (
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    input  wire logic                i_reset_pin_n,
    input  wire logic                i_parallel_bridge_mode,
    input  wire afp_pkg::afp_flags_t i_flags,
    input  wire logic                i_mute_ramp_node,
    input  wire logic                o_mute_ramp_node_oe,
    input  wire logic                o_mute_ramp_charge,
    input  wire logic [3:0]          o_hb_enable,
    input  wire logic [3:0]          o_hb_pulldown,
    input  wire logic [1:0]          o_flip,
    input  wire logic [1:0]          o_inject,
    input  wire logic                o_low_power,
    input  wire logic                o_fault_oe,
    input  wire logic                o_thermal_clip_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Five samples cover the two-stage synchroniser plus the latch stage.
    sequence ote_hold_s;
        (i_reset_pin_n && i_flags.thermal_shutdown)[*5];
    endsequence
    pulldown_in_reset_a: assert property ((!i_reset_pin_n)[*3] |-> o_hb_pulldown == 4'hF)
        else $error("pull-downs off in reset");
    fault_masked_a: assert property ((!i_reset_pin_n)[*3] |-> !o_fault_oe)
        else $error("fault shown in reset");
    low_power_hiz_a: assert property (o_low_power |-> o_hb_enable == 4'h0)
        else $error("bridge on in low power");
    check_fault_a: assert property ($rose(i_reset_pin_n) |-> ##[2:4] o_fault_oe)
        else $error("fault not low in short check");
    ote_trip_a: assert property (ote_hold_s |-> o_fault_oe)
        else $error("thermal trip not flagged");
    ote_latch_a: assert property (ote_hold_s ##1 i_reset_pin_n[*8] |->
        o_fault_oe && o_hb_enable == 4'h0) else $error("thermal latch lost");
    warn_pin_a: assert property ((i_reset_pin_n && i_flags.thermal_warning)[*4]
        |-> o_thermal_clip_oe) else $error("no thermal warning");
    boot_uv_a: assert property (i_flags.boot_uv[1][*3] |-> !o_hb_enable[1])
        else $error("half-bridge on in boot undervoltage");
    inject_pulse_a: assert property (o_inject[0] |=> (!o_inject[0])[*8])
        else $error("inject pulse too long");
endmodule // afp_seq_assertions
bind afp_seq afp_seq_assertions #(.RAMP_CYCLES(RAMP_CYCLES), .OLP_MAX(OLP_MAX)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reset_pin_n(i_reset_pin_n),
    .i_parallel_bridge_mode(i_parallel_bridge_mode), .i_flags(i_flags),
    .i_mute_ramp_node(i_mute_ramp_node), .o_mute_ramp_node_oe(o_mute_ramp_node_oe),
    .o_mute_ramp_charge(o_mute_ramp_charge), .o_hb_enable(o_hb_enable),
    .o_hb_pulldown(o_hb_pulldown), .o_flip(o_flip), .o_inject(o_inject),
    .o_low_power(o_low_power), .o_fault_oe(o_fault_oe), .o_thermal_clip_oe(o_thermal_clip_oe));

// [test/tb.sv]
// Self-checking bench for afp_seq with a controller model on its pins.
// Assumes short ramp and hold counts set here.
`timescale 1ns/1ps
module tb;
    logic clk = 0, rstn = 0, rst_req = 0, mute_req = 0, pbm = 0;
    logic pin_n, node, fault_n, clip_n, node_oe, charge, low_power, fault_oe, clip_oe;
    logic [3:0] en, pd;
    logic [1:0] flip, inj;
    afp_pkg::afp_flags_t flags = '0;
    int fail_count = 0, tests_run = 0, i, k, nc, ni;
    initial forever #50 clk = ~clk;
    afp_seq #(.RAMP_CYCLES(50), .OLP_MAX(3)) u_dut (.i_clk(clk), .i_rstn(rstn),
        .i_reset_pin_n(pin_n), .i_parallel_bridge_mode(pbm), .i_flags(flags),
        .i_mute_ramp_node(node), .o_mute_ramp_node_oe(node_oe), .o_mute_ramp_charge(charge),
        .o_hb_enable(en), .o_hb_pulldown(pd), .o_flip(flip), .o_inject(inj),
        .o_low_power(low_power), .o_fault_oe(fault_oe), .o_thermal_clip_oe(clip_oe));
    afp_mcu_model #(.HOLD_CYC(400)) u_mcu (.i_clk(clk), .i_reset_req(rst_req),
        .i_mute_req(mute_req), .i_fault_oe(fault_oe), .i_thermal_clip_oe(clip_oe),
        .i_mute_oe(node_oe), .i_mute_charge(charge), .o_reset_pin_n(pin_n),
        .o_mute_node(node), .o_fault_n(fault_n), .o_clip_n(clip_n));
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [3:0] pick(input int s);
        pick = (s == 0) ? en : (s == 1) ? {3'b0, pin_n} : {2'b0, inj};
    endfunction
    // Bounded wait; running out counts as a mismatch and ends the run.
    task automatic wait_for(input int s, input logic [3:0] exp, input int n);
        for (i = 0; i < n && pick(s) !== exp; i++) tick(1);
        if (pick(s) !== exp) begin
            fail_count++;
            $display("ERROR %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        tick(4);
        chk(pd, 4'hF);
        chk(en, 4'h0);
        chk(fault_n, 1'b1);
        chk(low_power, 1'b1);
        @(posedge clk) rst_req <= 1'b1;
        wait_for(1, 4'h1, 2000);
        tick(5);
        chk(fault_n, 1'b0);
        chk(en, 4'h0);
        wait_for(0, 4'hF, 600);
        chk(fault_n, 1'b1);
        chk(pd, 4'h0);
        // Ground short first, then supply short, each over a fresh reset cycle.
        for (k = 0; k < 2; k++) begin
            @(posedge clk) rst_req <= 1'b0;
            flags.short_gnd <= (k == 0);
            flags.short_rail <= (k == 1);
            tick(5);
            chk(en, 4'hF);
            chk(fault_n, 1'b1);
            wait_for(0, 4'h0, 200);
            chk(low_power, 1'b1);
            chk(8'(i), 8'h31);
            @(posedge clk) rst_req <= 1'b1;
            wait_for(1, 4'h1, 2000);
            tick(300);
            chk(en, 4'h0);
            chk(fault_n, 1'b0);
            @(posedge clk) flags.short_gnd <= 1'b0;
            flags.short_rail <= 1'b0;
            wait_for(0, 4'hF, 600);
            // A rail short clears in the second step, so startup is one step shorter.
            chk(i < 150, k == 1);
        end
        @(posedge clk) flags.thermal_warning <= 1'b1;
        tick(5);
        chk({clip_n, fault_n, en}, 6'h1F);
        @(posedge clk) flags.thermal_warning <= 1'b0;
        flags.boot_uv[1] <= 1'b1;
        tick(5);
        chk({clip_n, fault_n, en}, 6'h3D);
        @(posedge clk) flags.boot_uv[1] <= 1'b0;
        wait_for(0, 4'hF, 10);
        @(posedge clk) flags.clipping[0] <= 1'b1;
        wait_for(2, 4'h1, 200);
        nc = 0;
        ni = 0;
        for (k = 0; k < 100; k++) begin
            tick(1);
            nc += !clip_n;
            ni += inj[0];
        end
        chk(8'(nc), 8'h14);
        chk(8'(ni), 8'h01);
        @(posedge clk) flags.clipping[0] <= 1'b0;
        tick(30);
        chk(clip_n, 1'b1);
        @(posedge clk) flags.thermal_shutdown <= 1'b1;
        tick(6);
        @(posedge clk) flags.thermal_shutdown <= 1'b0;
        tick(10);
        chk({fault_n, en}, 5'h00);
        @(posedge clk) rst_req <= 1'b0;
        tick(5);
        chk({fault_n, en}, 5'h10);
        @(posedge clk) rst_req <= 1'b1;
        wait_for(1, 4'h1, 2000);
        wait_for(0, 4'hF, 600);
        @(posedge clk) mute_req <= 1'b1;
        wait_for(0, 4'h0, 200);
        chk(low_power, 1'b0);
        @(posedge clk) mute_req <= 1'b0;
        wait_for(0, 4'hF, 600);
        // Current limit flips channel 0 and clears at the next frame.
        @(posedge clk) flags.over_current[0] <= 1'b1;
        tick(4);
        chk({flip, en}, 6'h1F);
        @(posedge clk) flags.over_current[0] <= 1'b0;
        tick(30);
        chk({flip, fault_n}, 3'h1);
        // Imbalance on channel 1 latches C and D off; parallel mode takes all four.
        @(posedge clk) flags.imbalance[1] <= 1'b1;
        wait_for(0, 4'h3, 200);
        @(posedge clk) flags.imbalance[1] <= 1'b0;
        tick(60);
        chk({fault_n, en}, 5'h03);
        @(posedge clk) pbm <= 1'b1;
        tick(1);
        chk(en, 4'h0);
        report_and_stop();
    end
endmodule // tb

// [verilog/afp_seq.sv]
// Control and protection sequencer for a two-channel switching power stage.
// Assumes comparator flags come from another domain and the mute node level
// arrives as a pin; outputs drive gate-enable logic and open-drain pins.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Contract
// - Power-down ramp lasts about 20 ms.
// - Reset low ramps down, then Hi-Z; with thermal or overload latched the code goes straight to Hi-Z.
// - Weak pull-downs on while reset low.
// - Fault pin forced high during reset.
// - Low-power state after reset ramp-down.
// - Mute low ramps down, Hi-Z, circuits powered; the code drops the enables without a ramp once the node reads low.
// - Protection fault: Hi-Z and fault low immediately.
// - Only overload and thermal shutdown latch.
// - Bridge-mode shutdown grouping by error location.
// - Bootstrap undervoltage kills only its half-bridge.
// - Overcurrent flips bridge until next frame.
// - Persistent overcurrent latches channel off.
// - Saturation injects pulses every fourth frame.
// - Clip pulses warning pin, about 500 ns.
// - Imbalance counts up, shuts channel at maximum.
// - Short check after reset; hold Hi-Z.
// - Check ground shorts, then rail shorts.
// - Fault low during check; each reset rechecks.
// - Over 125 C warns without stopping.
// - Over 155 C latches shutdown until reset.
// - Fault and warning pins open drain, active low.
module afp_seq #(
    parameter int unsigned RAMP_CYCLES = afp_pkg::RAMP_CYC,
    parameter int unsigned OLP_MAX     = afp_pkg::OLP_COUNT_MAX
) (
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_reset_pin_n,
    input  wire logic               i_parallel_bridge_mode,
    input  wire afp_pkg::afp_flags_t i_flags,
    input  wire logic               i_mute_ramp_node,
    output logic                    o_mute_ramp_node_oe,
    output logic                    o_mute_ramp_charge,
    output logic [3:0]              o_hb_enable,
    output logic [3:0]              o_hb_pulldown,
    output logic [1:0]              o_flip,
    output logic [1:0]              o_inject,
    output logic                    o_low_power,
    output logic                    o_fault_oe,
    output logic                    o_thermal_clip_oe
);

    ////////////////////////////////////////////////////////////////////////////

    localparam int FW = $bits(afp_pkg::afp_flags_t);

    logic [FW-1:0]       sync1_ff;
    logic [FW-1:0]       sync2_ff;
    logic [1:0]          rst_sync_ff;
    logic [1:0]          mute_sync_ff;
    afp_pkg::afp_flags_t fl;
    logic                rst_pin;
    logic                mute_low;
    logic                frame_ff;
    logic [7:0]          div_ff;
    logic [1:0]          frame_cnt_ff;
    afp_pkg::afp_state_t state_ff;
    logic [31:0]         tmr_ff;
    logic                ote_ff;
    logic [1:0]          olp_ff;
    logic [1:0]          flip_ff;
    logic [7:0]          olp_cnt_ff [2];
    logic [7:0]          clip_cnt_ff;
    logic                global_fault;
    logic [3:0]          local_off;
    logic [1:0]          ch_off;

    // Flags pass two flip-flops; the first stage is read only by the second.
    always_ff @(posedge i_clk) begin
        sync1_ff     <= i_flags;
        sync2_ff     <= sync1_ff;
        rst_sync_ff  <= {rst_sync_ff[0], i_reset_pin_n};
        mute_sync_ff <= {mute_sync_ff[0], i_mute_ramp_node};
    end

    assign fl         = afp_pkg::afp_flags_t'(sync2_ff);
    assign rst_pin    = rst_sync_ff[1];
    assign mute_low   = ~mute_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////

    // Switching-frame enable derived from the system clock.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || div_ff == 8'(afp_pkg::FRAME_DIV - 1)) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
        frame_ff <= i_rstn && div_ff == 8'(afp_pkg::FRAME_DIV - 1);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            frame_cnt_ff <= 2'h0;
        end else if (frame_ff) begin
            frame_cnt_ff <= frame_cnt_ff + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Sequencer. The mute node is charged by the device while ramping up and
    // discharged while ramping down; the timer stands in for the capacitor.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_ff <= afp_pkg::ST_OFF;
            tmr_ff   <= 32'h0;
        end else if (!rst_pin) begin
            if ((state_ff == afp_pkg::ST_RUN || state_ff == afp_pkg::ST_RAMP_UP) &&
                (ote_ff || |olp_ff)) begin
                // A latched bridge must stay in Hi-Z; a ramp-down would restart it.
                // The healthy channel loses its soft ramp too, traded for simplicity.
                state_ff <= afp_pkg::ST_OFF;
                tmr_ff   <= 32'h0;
            end else if (state_ff == afp_pkg::ST_RUN || state_ff == afp_pkg::ST_RAMP_UP) begin
                state_ff <= afp_pkg::ST_RAMP_DOWN;
                tmr_ff   <= 32'h0;
            end else if (state_ff == afp_pkg::ST_RAMP_DOWN) begin
                tmr_ff <= tmr_ff + 32'h1;
                if (tmr_ff >= 32'(RAMP_CYCLES - 1)) begin
                    state_ff <= afp_pkg::ST_OFF;
                end
            end else begin
                state_ff <= afp_pkg::ST_OFF;
            end
        end else begin
            unique case (state_ff)
                afp_pkg::ST_OFF: begin
                    state_ff <= afp_pkg::ST_CHECK_GND;
                    tmr_ff   <= 32'h0;
                end
                afp_pkg::ST_CHECK_GND: begin
                    tmr_ff <= fl.short_gnd ? 32'h0 : tmr_ff + 32'h1;
                    if (tmr_ff >= 32'(afp_pkg::SHORT_STEP_CYC - 1)) begin
                        state_ff <= afp_pkg::ST_CHECK_RAIL;
                        tmr_ff   <= 32'h0;
                    end
                end
                afp_pkg::ST_CHECK_RAIL: begin
                    tmr_ff <= fl.short_rail ? 32'h0 : tmr_ff + 32'h1;
                    if (tmr_ff >= 32'(afp_pkg::SHORT_STEP_CYC - 1)) begin
                        state_ff <= afp_pkg::ST_RAMP_UP;
                        tmr_ff   <= 32'h0;
                    end
                end
                afp_pkg::ST_RAMP_UP: begin
                    tmr_ff <= tmr_ff + 32'h1;
                    if (tmr_ff >= 32'(RAMP_CYCLES - 1)) begin
                        state_ff <= afp_pkg::ST_RUN;
                    end
                end
                afp_pkg::ST_RUN: begin
                    tmr_ff <= 32'h0;
                end
                afp_pkg::ST_RAMP_DOWN: begin
                    // A reset pulse cut short still earns a fresh short check.
                    state_ff <= afp_pkg::ST_CHECK_GND;
                    tmr_ff   <= 32'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Latched faults survive until the reset pin is taken low.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !rst_pin) begin
            ote_ff <= 1'b0;
        end else if (fl.thermal_shutdown) begin
            ote_ff <= 1'b1;
        end
    end

    // Overcurrent flip held for the rest of the frame, set wins over clear.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            flip_ff <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (|fl.over_current[2*c +: 2]) begin
                    flip_ff[c] <= 1'b1;
                end else if (frame_ff) begin
                    flip_ff[c] <= 1'b0;
                end
            end
        end
    end

    // One counter per channel: current limiting or imbalance in a frame counts
    // up; reaching the maximum latches the channel off.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !rst_pin) begin
            olp_cnt_ff[0] <= 8'h00;
            olp_cnt_ff[1] <= 8'h00;
            olp_ff        <= 2'b00;
        end else if (frame_ff) begin
            for (int c = 0; c < 2; c++) begin
                if (flip_ff[c] || fl.imbalance[c]) begin
                    if (olp_cnt_ff[c] >= 8'(OLP_MAX - 1)) begin
                        olp_ff[c] <= 1'b1;
                    end else begin
                        olp_cnt_ff[c] <= olp_cnt_ff[c] + 8'h01;
                    end
                end else if (olp_cnt_ff[c] != 8'h00) begin
                    olp_cnt_ff[c] <= olp_cnt_ff[c] - 8'h01;
                end
            end
        end
    end

    // Clip indication: a pulse of fixed width each frame while saturated.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            clip_cnt_ff <= 8'h00;
        end else if (frame_ff && (|fl.clipping || |flip_ff)) begin
            clip_cnt_ff <= 8'(afp_pkg::CLIP_PULSE_CYC);
        end else if (clip_cnt_ff != 8'h00) begin
            clip_cnt_ff <= clip_cnt_ff - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Supply faults self clear; thermal and overload stay latched.
    assign global_fault = fl.undervoltage_guard | fl.overvoltage_guard | ote_ff;

    // Overload and imbalance are local errors: mode decides the shutdown group.
    always_comb begin
        ch_off = olp_ff;
        if (i_parallel_bridge_mode && |olp_ff) begin
            ch_off = 2'b11;
        end
        local_off = {{2{ch_off[1]}}, {2{ch_off[0]}}};
    end

    always_comb begin
        o_hb_enable = 4'h0;
        if (state_ff == afp_pkg::ST_RUN || state_ff == afp_pkg::ST_RAMP_UP) begin
            if (!global_fault && !mute_low) begin
                o_hb_enable = ~local_off & ~fl.boot_uv;
            end
        end
        if (state_ff == afp_pkg::ST_RAMP_DOWN && !global_fault) begin
            o_hb_enable = ~local_off & ~fl.boot_uv;
        end
    end

    // Inject only while saturated, on every fourth frame.
    assign o_inject = (|frame_cnt_ff == 1'b0 && frame_ff) ?
                      ((fl.clipping | flip_ff) & ~ch_off) : 2'b00;

    assign o_flip              = flip_ff;
    assign o_hb_pulldown       = {4{!rst_pin}};
    assign o_low_power         = !rst_pin && state_ff == afp_pkg::ST_OFF;
    // Mute driver pulls the node low in off and ramp-down; the node charges in ramp-up and run.
    assign o_mute_ramp_node_oe = state_ff == afp_pkg::ST_OFF ||
                                 state_ff == afp_pkg::ST_RAMP_DOWN;
    assign o_mute_ramp_charge  = state_ff == afp_pkg::ST_RAMP_UP ||
                                 state_ff == afp_pkg::ST_RUN;

    // Open-drain enables: high pulls the pin low.
    assign o_fault_oe = rst_pin &&
                        (global_fault || |olp_ff ||
                         state_ff == afp_pkg::ST_CHECK_GND ||
                         state_ff == afp_pkg::ST_CHECK_RAIL);
    assign o_thermal_clip_oe = fl.thermal_warning || clip_cnt_ff != 8'h00;

endmodule // afp_seq
